// ==== src/cfss_regs.svh ====
// Register indices, field positions, codes and timing figures of the charger supervisor
`ifndef CFSS_REGS_SVH
`define CFSS_REGS_SVH

// ----------------------------------------------------------------------------
// Register indices (byte address = 4 * index)
// ----------------------------------------------------------------------------
`define CFSS_IDX_STATUS 6'h00
`define CFSS_IDX_SUPPLY 6'h01
`define CFSS_IDX_CTRL 6'h02
`define CFSS_IDX_VREG 6'h03
`define CFSS_IDX_ICHG 6'h04
`define CFSS_IDX_DPM 6'h05

// ----------------------------------------------------------------------------
// Field positions, reset values and regulation constants
// ----------------------------------------------------------------------------
`define CFSS_STATE_LSB 4
`define CFSS_SUPPLY_LSB 6
`define CFSS_CTRL_STATEN 6
`define CFSS_CTRL_CHGEN 1
`define CFSS_DPM_BIT 5
`define CFSS_STATEN_RST 1'h1
`define CFSS_CHGEN_RST 1'h1
`define CFSS_VREG_RST 13'h1068
`define CFSS_ICHG_RST 12'h3e8
`define CFSS_WARM_DROP_MV 13'h08c
`define CFSS_TREG_SPAN 4'ha

// ----------------------------------------------------------------------------
// State, fault and supply codes
// ----------------------------------------------------------------------------
`define CFSS_ST_NOSRC 3'h0
`define CFSS_ST_READY 3'h1
`define CFSS_ST_CHG 3'h3
`define CFSS_ST_DONE 3'h5
`define CFSS_ST_FAULT 3'h7
`define CFSS_FL_NORMAL 3'h0
`define CFSS_FL_TSD 3'h1
`define CFSS_FL_BATTEMP 3'h2
`define CFSS_FL_WDOG 3'h3
`define CFSS_FL_SAFETY 3'h4
`define CFSS_FL_SUPPLY 3'h5
`define CFSS_FL_BATT 3'h7
`define CFSS_SUP_NORMAL 2'h0
`define CFSS_SUP_OVP 2'h1
`define CFSS_SUP_WEAK 2'h2

// ----------------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------------
`define CFSS_CLK_PERIOD_NS 100
`define CFSS_PULSE_TIME_US 128
`define CFSS_DETECT_TIME_MS 32
`define CFSS_RETRY_TIME_S 2

`endif

// ==== src/cfss_pkg.sv ====
// Types shared by the charger supervisor modules
package cfss_pkg;

  // One-hot supervisor states
  typedef enum logic [6:0] {
    CFSS_OFF   = 7'h01,
    CFSS_DET   = 7'h02,
    CFSS_RETRY = 7'h04,
    CFSS_RUN   = 7'h08,
    CFSS_SLEEP = 7'h10,
    CFSS_TSD   = 7'h20,
    CFSS_SRCF  = 7'h40
  } cfss_state_t;

endpackage

// ==== src/cfss_pulse.sv ====
// Retriggerable fixed-width event pulse timer
`timescale 1ns/10ps
module cfss_pulse #(
  parameter int PULSE_CYC = 1280
) (
  // Clock and reset
  input wire logic clk,
  input wire logic nrst,
  // Trigger and pulse
  input wire logic trig,
  output logic active
);
  import cfss_pkg::*;

  logic [15:0] cnt;
  logic last;

  assign last = (cnt == 16'(PULSE_CYC - 1));

  // ----------------------------------------------------------------------------
  // Counter; a new event restarts the full width rather than merging
  // ----------------------------------------------------------------------------
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      cnt <= 16'h0000;
      active <= 1'b0;
    end else if (trig) begin
      cnt <= 16'h0000;
      active <= 1'b1;
    end else if (active) begin
      cnt <= last ? 16'h0000 : cnt + 16'h0001;
      active <= !last;
    end
  end

  // ----------------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);

  pulse_restart_a: assert property (trig |=> active && cnt == 16'h0000)
    else $error("pulse not restarted by event");
  pulse_width_a: assert property ($fell(active) |-> $past(cnt) == 16'(PULSE_CYC - 1))
    else $error("pulse ended at wrong width");
  pulse_seen_c: cover property ($fell(active));

endmodule // cfss_pulse

// ==== src/cfss_top.sv ====
// Charger fault and status supervisor with AHB-Lite register slave
`timescale 1ns/10ps
`include "cfss_regs.svh"
module cfss_top #(
  parameter int DET_CYC = (`CFSS_DETECT_TIME_MS * 1000000) / `CFSS_CLK_PERIOD_NS,
  parameter int RETRY_CYC = (`CFSS_RETRY_TIME_S * 1000000000) / `CFSS_CLK_PERIOD_NS
) (
  // Clock and reset
  input wire logic clk,
  input wire logic nrst,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  // Thermistor comparators (thermistor_sense_input against fixed fractions)
  input wire logic therm_below_hot,
  input wire logic therm_below_warm,
  input wire logic therm_above_cool,
  input wire logic therm_above_cold,
  // Die temperature
  input wire logic [3:0] die_excess,
  input wire logic die_over_shutdown,
  input wire logic die_cooled,
  // Supply comparators
  input wire logic source_present,
  input wire logic supply_below_lockout,
  input wire logic supply_below_sleep,
  input wire logic supply_below_droop,
  input wire logic supply_below_weak,
  input wire logic supply_above_ovp,
  // Other charger events
  input wire logic charge_done,
  input wire logic safety_fault,
  input wire logic wdog_expired,
  input wire logic bat_fault,
  // Power stage control
  output logic conv_enable,
  output logic charge_active,
  output logic timers_suspend,
  output logic sink_enable,
  output logic driver_supply_regulator_en,
  output logic input_limit_reduce,
  output logic [12:0] vreg_target,
  output logic [11:0] ichg_target,
  // Open-drain status and interrupt pins
  output logic stat_o,
  output logic stat_oe,
  output logic int_o,
  output logic int_oe
);
  import cfss_pkg::*;

  cfss_state_t state;
  cfss_state_t next_state;
  logic [24:0] tmr;
  logic [2:0] state_code;
  logic [2:0] fault_code;
  logic [1:0] supply_code;
  logic [2:0] next_fault;
  logic [1:0] next_supply;
  logic stat_en;
  logic chg_en;
  logic [12:0] vreg_prog;
  logic [11:0] ichg_prog;
  logic dpm_flag;
  logic wr_pend;
  logic [5:0] wr_idx;
  logic src_q;
  logic safety_q;
  logic wdog_q;
  logic therm_q;
  logic bat_q;
  logic pulse_act;

  // ----------------------------------------------------------------------------
  // Condition decode
  // ----------------------------------------------------------------------------
  wire therm_fault = therm_below_hot || therm_above_cold;
  // Warm and cool come only from fixed-ratio comparators; nothing to program
  wire therm_warm = !therm_below_hot && therm_below_warm;
  wire therm_cool = therm_above_cool && !therm_above_cold;
  wire powered = source_present && !supply_below_lockout;
  wire det_end = (tmr == 25'(DET_CYC - 1));
  wire retry_end = (tmr == 25'(RETRY_CYC - 1));
  wire in_run = (next_state == CFSS_RUN);
  wire next_charging = in_run && chg_en && !therm_fault && !charge_done && !safety_fault;
  wire fault_entry = (next_state != state) && (next_state == CFSS_TSD ||
    next_state == CFSS_SLEEP || next_state == CFSS_SRCF || next_state == CFSS_RETRY);
  wire input_events = (source_present != src_q) || (safety_fault && !safety_q) ||
    (wdog_expired && !wdog_q) || (therm_fault && !therm_q) || (bat_fault && !bat_q);
  wire event_trig = fault_entry || input_events;

  // ----------------------------------------------------------------------------
  // Supervisor state machine
  // ----------------------------------------------------------------------------
  always_comb begin
    next_state = state;
    next_supply = supply_code;
    if (!powered) begin
      next_state = CFSS_OFF;
      next_supply = `CFSS_SUP_NORMAL;
    end else if (die_over_shutdown) begin
      next_state = CFSS_TSD;
    end else begin
      case (state)
        CFSS_OFF: begin
          next_state = CFSS_DET;
        end
        CFSS_DET: begin
          // Overvoltage is not looked at until the interval ends
          if (supply_below_weak) begin
            next_state = CFSS_RETRY;
            next_supply = `CFSS_SUP_WEAK;
          end else if (det_end && supply_above_ovp) begin
            next_state = CFSS_RETRY;
            next_supply = `CFSS_SUP_OVP;
          end else if (det_end) begin
            next_state = CFSS_RUN;
            next_supply = `CFSS_SUP_NORMAL;
          end
        end
        CFSS_RETRY: begin
          if (retry_end) begin
            next_state = CFSS_DET;
          end
        end
        CFSS_RUN: begin
          if (supply_below_sleep) begin
            next_state = CFSS_SLEEP;
          end else if (supply_below_weak) begin
            next_state = CFSS_SRCF;
            next_supply = `CFSS_SUP_WEAK;
          end else if (supply_above_ovp) begin
            next_state = CFSS_SRCF;
            next_supply = `CFSS_SUP_OVP;
          end
        end
        CFSS_SLEEP: begin
          if (!supply_below_sleep) begin
            next_state = CFSS_RUN;
          end
        end
        CFSS_TSD: begin
          if (die_cooled) begin
            next_state = CFSS_RUN;
          end
        end
        CFSS_SRCF: begin
          if (!supply_below_weak && !supply_above_ovp) begin
            next_state = CFSS_RUN;
            next_supply = `CFSS_SUP_NORMAL;
          end
        end
        default: begin
          next_state = CFSS_OFF;
        end
      endcase
    end
  end

  // Fault code follows the state; the first cause found wins
  always_comb begin
    next_fault = `CFSS_FL_NORMAL;
    if (next_state == CFSS_TSD) begin
      next_fault = `CFSS_FL_TSD;
    end else if (next_state == CFSS_SLEEP || next_state == CFSS_SRCF ||
        next_state == CFSS_RETRY) begin
      next_fault = `CFSS_FL_SUPPLY;
    end else if (in_run && bat_fault) begin
      next_fault = `CFSS_FL_BATT;
    end else if (in_run && safety_fault) begin
      next_fault = `CFSS_FL_SAFETY;
    end else if (in_run && therm_fault) begin
      next_fault = `CFSS_FL_BATTEMP;
    end else if (in_run && wdog_expired) begin
      next_fault = `CFSS_FL_WDOG;
    end
  end

  // State register and detection/retry interval counter
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      state <= CFSS_OFF;
      tmr <= 25'h0000000;
      fault_code <= `CFSS_FL_NORMAL;
      supply_code <= `CFSS_SUP_NORMAL;
    end else begin
      state <= next_state;
      tmr <= (next_state != state) ? 25'h0000000 : tmr + 25'h0000001;
      fault_code <= next_fault;
      supply_code <= next_supply;
    end
  end

  // State code: faults override the run-time status
  wire [2:0] next_state_code =
    (next_state == CFSS_OFF || next_state == CFSS_DET) ? `CFSS_ST_NOSRC :
    (next_fault != `CFSS_FL_NORMAL) ? `CFSS_ST_FAULT :
    next_charging ? `CFSS_ST_CHG :
    (in_run && charge_done) ? `CFSS_ST_DONE : `CFSS_ST_READY;

  // ----------------------------------------------------------------------------
  // Regulation targets
  // ----------------------------------------------------------------------------
  wire [11:0] ichg_base = therm_cool ? (ichg_prog >> 1) : ichg_prog;
  wire [3:0] treg_left = (die_excess >= `CFSS_TREG_SPAN) ? 4'h0 :
    `CFSS_TREG_SPAN - die_excess;
  wire [15:0] ichg_prod = ichg_base * treg_left;
  // Linear taper, zero at ten degrees over; a constant divide keeps it exact
  wire [11:0] next_ichg = 12'(ichg_prod / 16'(`CFSS_TREG_SPAN));
  wire [12:0] next_vreg = therm_warm ? vreg_prog - `CFSS_WARM_DROP_MV : vreg_prog;

  // ----------------------------------------------------------------------------
  // Power stage outputs and event edge history
  // ----------------------------------------------------------------------------
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      conv_enable <= 1'b0;
      charge_active <= 1'b0;
      timers_suspend <= 1'b0;
      sink_enable <= 1'b0;
      driver_supply_regulator_en <= 1'b0;
      input_limit_reduce <= 1'b0;
      dpm_flag <= 1'b0;
      vreg_target <= `CFSS_VREG_RST;
      ichg_target <= `CFSS_ICHG_RST;
      state_code <= `CFSS_ST_NOSRC;
      src_q <= 1'b0;
      safety_q <= 1'b0;
      wdog_q <= 1'b0;
      therm_q <= 1'b0;
      bat_q <= 1'b0;
    end else begin
      conv_enable <= in_run;
      charge_active <= next_charging;
      timers_suspend <= therm_fault || (next_state == CFSS_TSD);
      sink_enable <= (next_state == CFSS_DET);
      driver_supply_regulator_en <= powered && next_state != CFSS_SLEEP &&
        next_state != CFSS_TSD;
      input_limit_reduce <= in_run && supply_below_droop;
      dpm_flag <= in_run && supply_below_droop;
      vreg_target <= next_vreg;
      ichg_target <= next_ichg;
      state_code <= next_state_code;
      src_q <= source_present;
      safety_q <= safety_fault;
      wdog_q <= wdog_expired;
      therm_q <= therm_fault;
      bat_q <= bat_fault;
    end
  end

  // ----------------------------------------------------------------------------
  // Event pulse and open-drain pins
  // ----------------------------------------------------------------------------
  cfss_pulse #(
    .PULSE_CYC((`CFSS_PULSE_TIME_US * 1000 + `CFSS_CLK_PERIOD_NS - 1) / `CFSS_CLK_PERIOD_NS)
  ) u_pulse (
    .clk(clk),
    .nrst(nrst),
    .trig(event_trig),
    .active(pulse_act)
  );

  // Pulse ignores the enable; both pins share one drive term
  wire next_pin_oe = pulse_act || (charge_active && stat_en);

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      stat_oe <= 1'b0;
      int_oe <= 1'b0;
      stat_o <= 1'b0;
      int_o <= 1'b0;
    end else begin
      stat_oe <= next_pin_oe;
      int_oe <= next_pin_oe;
      stat_o <= 1'b0;
      int_o <= 1'b0;
    end
  end

  // ----------------------------------------------------------------------------
  // AHB-Lite register slave, zero wait states
  // ----------------------------------------------------------------------------
  wire addr_ok = hsel && htrans[1] && hready;
  wire [5:0] a_idx = haddr[7:2];
  wire a_mapped = (haddr[31:8] == 24'h000000);
  wire [31:0] rd_mux =
    !a_mapped ? 32'h00000000 :
    (a_idx == `CFSS_IDX_STATUS) ? {25'h0, state_code, 1'b0, fault_code} :
    (a_idx == `CFSS_IDX_SUPPLY) ? {24'h0, supply_code, 6'h00} :
    (a_idx == `CFSS_IDX_CTRL) ? {25'h0, stat_en, 4'h0, chg_en, 1'b0} :
    (a_idx == `CFSS_IDX_VREG) ? {19'h0, vreg_prog} :
    (a_idx == `CFSS_IDX_ICHG) ? {20'h0, ichg_prog} :
    (a_idx == `CFSS_IDX_DPM) ? {26'h0, dpm_flag, 5'h00} : 32'h00000000;

  // Address phase capture; read data is ready for the following data phase
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      wr_pend <= 1'b0;
      wr_idx <= 6'h00;
      hrdata <= 32'h00000000;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end else begin
      wr_pend <= addr_ok && hwrite && a_mapped;
      wr_idx <= a_idx;
      hrdata <= (addr_ok && !hwrite) ? rd_mux : hrdata;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end
  end

  // Data phase write of the writable registers
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      stat_en <= `CFSS_STATEN_RST;
      chg_en <= `CFSS_CHGEN_RST;
      vreg_prog <= `CFSS_VREG_RST;
      ichg_prog <= `CFSS_ICHG_RST;
    end else if (wr_pend) begin
      if (wr_idx == `CFSS_IDX_CTRL) begin
        stat_en <= hwdata[`CFSS_CTRL_STATEN];
        chg_en <= hwdata[`CFSS_CTRL_CHGEN];
      end else if (wr_idx == `CFSS_IDX_VREG) begin
        vreg_prog <= hwdata[12:0];
      end else if (wr_idx == `CFSS_IDX_ICHG) begin
        ichg_prog <= hwdata[11:0];
      end
    end
  end

  // ----------------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);

  therm_suspend_a: assert property (therm_fault |=> timers_suspend && !charge_active)
    else $error("thermistor fault did not suspend");
  warm_vreg_a: assert property (therm_warm |=> vreg_target ==
    $past(vreg_prog) - `CFSS_WARM_DROP_MV)
    else $error("warm drop missing");
  cool_half_a: assert property (therm_cool && die_excess == 4'h0 |=>
    ichg_target == ($past(ichg_prog) >> 1))
    else $error("cool current not halved");
  treg_zero_a: assert property (die_excess >= `CFSS_TREG_SPAN |=> ichg_target == 12'h000)
    else $error("current not zero at full taper");
  tsd_off_a: assert property (powered && die_over_shutdown && state != CFSS_TSD |=> !conv_enable
    && !driver_supply_regulator_en && timers_suspend && pulse_act)
    else $error("shutdown did not stop stage");
  sleep_entry_a: assert property (state == CFSS_RUN && powered && supply_below_sleep &&
    !die_over_shutdown |=> state == CFSS_SLEEP && fault_code == `CFSS_FL_SUPPLY ##1 pulse_act)
    else $error("sleep not entered");
  det_ovp_a: assert property (state == CFSS_DET && powered && !die_over_shutdown &&
    !supply_below_weak && !det_end |=> state == CFSS_DET)
    else $error("detection left early");
  det_end_a: assert property (state == CFSS_DET && det_end && supply_above_ovp |=>
    !conv_enable)
    else $error("converter started over voltage");
  int_same_a: assert property (int_oe == stat_oe && !stat_o && !int_o)
    else $error("pins differ");
  stat_low_a: assert property (charge_active && stat_en |=> stat_oe)
    else $error("status pin not low while charging");

  run_seen_c: cover property (state == CFSS_DET ##1 state == CFSS_RUN);
  retry_seen_c: cover property (state == CFSS_RETRY ##1 state == CFSS_DET);
  tsd_seen_c: cover property (state == CFSS_TSD ##1 state == CFSS_RUN);

endmodule // cfss_top

// ==== testbench/cfss_host_model.sv ====
// Host model watching the open-drain status and interrupt lines
`timescale 1ns/10ps
module cfss_host_model (
  // Clock and reset
  input wire logic clk,
  input wire logic nrst,
  // Pin drivers of the block
  input wire logic stat_o,
  input wire logic stat_oe,
  input wire logic int_o,
  input wire logic int_oe,
  // Reports to the bench
  output logic pulse_seen,
  output int pulse_len,
  output logic lines_differ
);
  logic stat_line;
  logic int_line;
  int low_cnt;
  // Pull-ups lift a released line, so an undriven pin never reads as a stale low
  assign stat_line = stat_oe ? stat_o : 1'b1;
  assign int_line = int_oe ? int_o : 1'b1;
  // Time each low period; its length is reported in the cycle after release
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      low_cnt <= 0;
      pulse_seen <= 1'b0;
      pulse_len <= 0;
      lines_differ <= 1'b0;
    end else begin
      low_cnt <= stat_line ? 0 : low_cnt + 1;
      pulse_seen <= stat_line && (low_cnt != 0);
      pulse_len <= low_cnt;
      if (stat_line !== int_line) lines_differ <= 1'b1;
    end
  end
endmodule // cfss_host_model

// ==== testbench/charger_fault_status_supervisor_tb.sv ====
// Self-checking bench for the charger fault and status supervisor
`timescale 1ns/10ps
`include "cfss_regs.svh"
module charger_fault_status_supervisor_tb;
  logic clk = 1'b0, nrst = 1'b0, hsel = 1'b0, hwrite = 1'b0, src = 1'b0, done = 1'b0;
  logic die_over = 1'b0, die_cool = 1'b1, watch = 1'b1, rd_ph = 1'b0;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata;
  logic [1:0] htrans = 2'h0;
  logic [2:0] tzone = 3'h0, hsize = 3'h0;
  logic [3:0] flt = 4'h0, dexc = 4'h0;
  logic [4:0] sup = 5'h0;
  logic hrdy, hresp, conv, chg, tsus, sink, dreg, ilim, so, soe, io, ioe, seen, differ;
  logic [12:0] vreg;
  logic [11:0] ichg;
  int plen, err_total, checks_done, v, i, e;
  logic [31:0] rd_q[$], pl_q[$];
  logic [4:0] sb [3] = '{5'h02, 5'h08, 5'h10};
  logic [31:0] sr [3] = '{32'h0, 32'h80, 32'h40};

  // Short detection and retry spans keep the run brief
  cfss_top #(.DET_CYC(20), .RETRY_CYC(40)) cfss_top_inst (.clk(clk), .nrst(nrst),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
    .hwdata(hwdata), .hready(hrdy), .hreadyout(hrdy), .hresp(hresp), .hrdata(hrdata),
    .therm_below_hot(flt[0]), .therm_below_warm(tzone[0]), .therm_above_cool(tzone[1]),
    .therm_above_cold(tzone[2]), .die_excess(dexc), .die_over_shutdown(die_over),
    .die_cooled(die_cool), .source_present(src), .supply_below_lockout(sup[0]),
    .supply_below_sleep(sup[1]), .supply_below_droop(sup[2]), .supply_below_weak(sup[3]),
    .supply_above_ovp(sup[4]), .charge_done(done), .safety_fault(flt[1]),
    .wdog_expired(flt[2]), .bat_fault(flt[3]), .conv_enable(conv), .charge_active(chg),
    .timers_suspend(tsus), .sink_enable(sink), .driver_supply_regulator_en(dreg),
    .input_limit_reduce(ilim), .vreg_target(vreg), .ichg_target(ichg), .stat_o(so),
    .stat_oe(soe), .int_o(io), .int_oe(ioe));
  cfss_host_model cfss_host_model_inst (.clk(clk), .nrst(nrst), .stat_o(so), .stat_oe(soe),
    .int_o(io), .int_oe(ioe), .pulse_seen(seen), .pulse_len(plen), .lines_differ(differ));

  always #50 clk = ~clk;

  task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      err_total++;
      $display("ERROR %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask
  // Single word transfer: address phase held until ready, then the data phase
  task automatic ahb(input logic wr, input logic [5:0] idx, input logic [31:0] d);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= wr;
    hsize <= 3'h2;
    haddr <= {24'h0, idx, 2'h0};
    cyc(1);
    while (!hrdy) cyc(1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    cyc(1);
    while (!hrdy) cyc(1);
  endtask
  task automatic rd(input logic [5:0] idx, input logic [31:0] x);
    rd_q.push_back(x);
    ahb(1'b0, idx, 32'h0);
  endtask
  task automatic finish_test();
    if (err_total == 0 && checks_done > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  // Each read data phase, and each finished pulse while watch is set, takes the oldest note off its queue
  always @(posedge clk) begin
    if (rd_ph) chk("hrdata", hrdata, rd_q.pop_front());
    rd_ph <= nrst && hsel && htrans[1] && !hwrite && hrdy;
    if (seen && watch) chk("pulse_len", 32'(plen), pl_q.pop_front());
  end

  // Main sequence
  initial begin
    void'($urandom(37));
    cyc(6);
    nrst <= 1'b1;
    cyc(1);
    rd(`CFSS_IDX_CTRL, 32'h42);
    rd(`CFSS_IDX_VREG, 32'(`CFSS_VREG_RST));
    rd(`CFSS_IDX_ICHG, 32'(`CFSS_ICHG_RST));
    rd(6'h06, 32'h0);
    chk("hresp", hresp, 1'b0);
    // Status level off, so every low on the pin until the level is turned back on is an event pulse
    ahb(1'b1, `CFSS_IDX_CTRL, 32'h02);
    src <= 1'b1;
    pl_q.push_back(32'd1280);
    cyc(5);
    chk("sink", sink, 1'b1);
    chk("conv", conv, 1'b0);
    cyc(30);
    chk("conv", conv, 1'b1);
    chk("dreg", dreg, 1'b1);
    rd(`CFSS_IDX_STATUS, 32'h30);
    cyc(1400);
    // Plug pulse over: charging with the level disabled leaves the pin released
    chk("chg", chg, 1'b1);
    chk("stat_oe", soe, 1'b0);
    // Warm and cool zones against random targets; first pass reaches the full taper
    for (int k = 0; k < 3; k++) begin
      v = 3500 + $urandom % 941;
      i = 500 + $urandom % 2001;
      e = (k == 0) ? 10 + $urandom % 6 : $urandom % 10;
      ahb(1'b1, `CFSS_IDX_VREG, 32'(v));
      ahb(1'b1, `CFSS_IDX_ICHG, 32'(i));
      tzone <= 3'h1;
      dexc <= 4'(e);
      cyc(3);
      chk("vreg", vreg, 32'(v - 140));
      chk("ichg", ichg, 32'(e >= 10 ? 0 : i * (10 - e) / 10));
      tzone <= 3'h2;
      dexc <= 4'h0;
      cyc(3);
      chk("vreg", vreg, 32'(v));
      chk("ichg", ichg, 32'(i / 2));
      tzone <= 3'h0;
    end
    // Each fault input gives one pulse; a hot pack halts charge and timers
    for (int j = 0; j < 4; j++) begin
      flt <= 4'(1 << j);
      pl_q.push_back(32'd1280);
      cyc(5);
      if (j == 0) chk("chg", chg, 1'b0);
      if (j == 0) chk("tsus", tsus, 1'b1);
      flt <= 4'h0;
      cyc(1400);
    end
    // Shutdown; recovery waits for the cooled die
    die_over <= 1'b1;
    die_cool <= 1'b0;
    pl_q.push_back(32'd1280);
    cyc(3);
    chk("conv", conv, 1'b0);
    chk("tsus", tsus, 1'b1);
    chk("dreg", dreg, 1'b0);
    rd(`CFSS_IDX_STATUS, 32'h71);
    die_over <= 1'b0;
    cyc(3);
    chk("conv", conv, 1'b0);
    die_cool <= 1'b1;
    cyc(3);
    chk("conv", conv, 1'b1);
    cyc(1400);
    // Sleep, weak source and overvoltage while running
    for (int j = 0; j < 3; j++) begin
      sup <= sb[j];
      pl_q.push_back(32'd1280);
      cyc(3);
      chk("conv", conv, 1'b0);
      chk("dreg", dreg, 32'(j != 0));
      rd(`CFSS_IDX_SUPPLY, sr[j]);
      sup <= 5'h0;
      cyc(3);
      chk("conv", conv, 1'b1);
      cyc(1400);
    end
    sup <= 5'h04;
    cyc(3);
    chk("ilim", ilim, 1'b1);
    rd(`CFSS_IDX_DPM, 32'h20);
    // Replug: lockout, overvoltage ignored then refused, weak retry
    watch <= 1'b0;
    src <= 1'b0;
    cyc(3);
    src <= 1'b1;
    sup <= 5'h11;
    cyc(5);
    chk("dreg", dreg, 1'b0);
    sup <= 5'h10;
    cyc(10);
    chk("sink", sink, 1'b1);
    cyc(20);
    chk("conv", conv, 1'b0);
    sup <= 5'h08;
    cyc(40);
    chk("sink", sink, 1'b0);
    rd(`CFSS_IDX_SUPPLY, 32'h80);
    sup <= 5'h0;
    cyc(100);
    chk("conv", conv, 1'b1);
    cyc(1400);
    watch <= 1'b1;
    ahb(1'b1, `CFSS_IDX_CTRL, 32'h42);
    cyc(3);
    chk("stat_oe", soe, 1'b1);
    chk("int_oe", ioe, 1'b1);
    chk("differ", differ, 1'b0);
    chk("pulses_left", 32'(pl_q.size()), 32'h0);
    // Charge complete: the level is released, so its end is no event pulse
    watch <= 1'b0;
    done <= 1'b1;
    cyc(3);
    chk("stat_oe", soe, 1'b0);
    rd(`CFSS_IDX_STATUS, 32'h50);
    cyc(1);
    finish_test();
  end

  // Cut a hang short well beyond the expected run length
  initial begin
    cyc(40000);
    err_total++;
    finish_test();
  end
endmodule // charger_fault_status_supervisor_tb
